/* File: shared/pdsr_pkg.sv */
package pdsr_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_EXT_CAP = 10'h11e;
    localparam logic [9:0] IDX_LOOPBACK = 10'h122;
    localparam logic [9:0] IDX_CABLE_DIAG = 10'h124;
    localparam logic [9:0] IDX_LINK_STATUS = 10'h126;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h130;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h131;

    localparam int ADDR_W = 12;
    localparam int IRQ_W = 3;

    // fixed capability word: 1000BASE-T full and half, no 1000BASE-X
    localparam logic [15:0] EXT_CAP_VALUE = 16'h3000;

    // loopback register layout
    localparam int LB_ENABLE_BIT = 8;
    localparam int LB_RC_BIT = 1;
    localparam logic [15:0] LB_RESET = 16'h00f4;
    localparam logic [15:0] LB_WRITE_MASK = 16'hfffe;

    // cable diagnostic register layout
    localparam int CD_ENABLE_BIT = 15;
    localparam int CD_SPARE_BIT = 14;
    localparam int CD_PAIR_LSB = 12;
    localparam int CD_SPARE2_LSB = 10;
    localparam int CD_STATUS_LSB = 8;
    localparam logic [1:0] CD_PAIR_RESET = 2'h0;
    localparam logic [1:0] CD_STATUS_RESET = 2'h0;

    // link status layout
    localparam int LS_GIG_BIT = 1;
    localparam int LS_FAST_BIT = 0;

    // interrupt event positions
    localparam int EV_TEST_DONE = 0;
    localparam int EV_GIG_CHANGE = 1;
    localparam int EV_FAST_CHANGE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    typedef enum logic [1:0] {
        PDSR_PAIR_A,
        PDSR_PAIR_B,
        PDSR_PAIR_C,
        PDSR_PAIR_D
    } pdsr_pair_t;

    typedef enum logic [1:0] {
        PDSR_CABLE_NORMAL,
        PDSR_CABLE_OPEN,
        PDSR_CABLE_SHORT,
        PDSR_CABLE_RSVD
    } pdsr_cable_t;

endpackage : pdsr_pkg

/* File: hw/pdsr_loopback.sv */
`timescale 1ns/1ps

// one data path with a remote loopback turnaround
module pdsr_loopback #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loop_en,
    input wire logic [WIDTH-1:0] ext_in_data,
    input wire logic ext_in_valid,
    input wire logic [WIDTH-1:0] fab_in_data,
    input wire logic fab_in_valid,
    output logic [WIDTH-1:0] ext_out_data,
    output logic ext_out_valid,
    output logic [WIDTH-1:0] fab_out_data,
    output logic fab_out_valid
);
    import pdsr_pkg::*;

    // external input turns back outward, fabric data still follows it but valid is low while looping
    wire logic [WIDTH-1:0] ext_sel_data = loop_en ? ext_in_data : fab_in_data;
    wire logic ext_sel_valid = loop_en ? ext_in_valid : fab_in_valid;
    wire logic fab_sel_valid = ext_in_valid & ~loop_en;

    // one register stage both ways so latency does not depend on mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_out_data <= '0;
            ext_out_valid <= 1'b0;
            fab_out_data <= '0;
            fab_out_valid <= 1'b0;
        end else begin
            ext_out_data <= ext_sel_data;
            ext_out_valid <= ext_sel_valid;
            fab_out_data <= ext_in_data;
            fab_out_valid <= fab_sel_valid;
        end
    end

endmodule : pdsr_loopback

/* File: hw/pdsr_regs.sv */
`timescale 1ns/1ps

module pdsr_regs #(
    parameter int LINE_W = 8,
    parameter int MIP_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [pdsr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // cable measurement engine
    output logic diag_start,
    output logic diag_abort,
    output logic [1:0] diag_pair,
    input wire logic diag_done,
    input wire logic [1:0] diag_result,
    // link state from the phy, asynchronous to clk
    input wire logic link_gig_up,
    input wire logic link_fast_up,
    // copper data path
    input wire logic [LINE_W-1:0] line_rx_data,
    input wire logic line_rx_valid,
    output logic [LINE_W-1:0] line_tx_data,
    output logic line_tx_valid,
    input wire logic [LINE_W-1:0] fab_tx_data,
    input wire logic fab_tx_valid,
    output logic [LINE_W-1:0] fab_rx_data,
    output logic fab_rx_valid,
    // media independent port data path
    input wire logic [MIP_W-1:0] media_independent_port_txd,
    input wire logic media_independent_port_tx_en,
    output logic [MIP_W-1:0] media_independent_port_rxd,
    output logic media_independent_port_rx_dv,
    input wire logic [MIP_W-1:0] mip_fab_data,
    input wire logic mip_fab_valid,
    output logic [MIP_W-1:0] mip_to_fab_data,
    output logic mip_to_fab_valid
);
    import pdsr_pkg::*;

    // expand byte enables into a bit mask for the low half word
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    logic ack_q;
    logic [31:0] rdata_q;
    logic [15:0] lb_q;
    logic busy_q;
    logic spare_q;
    logic [1:0] pair_q;
    logic [1:0] spare2_q;
    logic [1:0] cable_q;
    logic start_q;
    logic abort_q;
    logic gig_m_q;
    logic gig_q;
    logic fast_m_q;
    logic fast_q;
    logic gig_old_q;
    logic fast_old_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [15:0] lb_d;
    logic [IRQ_W-1:0] irq_st_d;

    // one wait cycle per access; the access completes on the ack cycle
    wire logic req = avs_read | avs_write;
    wire logic wr_go = avs_write & ack_q;
    wire logic rd_go = avs_read & ack_q;
    wire logic [9:0] idx = avs_address[ADDR_W-1:2];
    wire logic [15:0] wmask = lane_mask(avs_byteenable);
    wire logic [15:0] wdat = avs_writedata[15:0];

    wire logic sel_cap = idx == IDX_EXT_CAP;
    wire logic sel_lb = idx == IDX_LOOPBACK;
    wire logic sel_cd = idx == IDX_CABLE_DIAG;
    wire logic sel_ls = idx == IDX_LINK_STATUS;
    wire logic sel_ist = idx == IDX_IRQ_STATUS;
    wire logic sel_imk = idx == IDX_IRQ_MASK;

    // cable register write decode, upper byte lane carries all fields
    wire logic cd_wr = wr_go & sel_cd & avs_byteenable[1];
    wire logic cd_start = cd_wr & wdat[CD_ENABLE_BIT] & ~busy_q;
    wire logic cd_abort = cd_wr & ~wdat[CD_ENABLE_BIT] & busy_q;
    wire logic cd_finish = busy_q & diag_done & ~cd_abort;

    // link change detection on the synchronised levels
    wire logic gig_chg = gig_q ^ gig_old_q;
    wire logic fast_chg = fast_q ^ fast_old_q;
    wire logic [IRQ_W-1:0] ev = {fast_chg, gig_chg, cd_finish};

    // register views
    wire logic [15:0] cd_view = {busy_q, spare_q, pair_q, spare2_q,
                                 cable_q, 8'h00};
    wire logic [15:0] ls_view = {14'h0000, gig_q, fast_q};

    // read multiplexer; unmapped words read zero
    wire logic [15:0] rd_mux =
        sel_cap ? EXT_CAP_VALUE :
        sel_lb ? lb_q :
        sel_cd ? cd_view :
        sel_ls ? ls_view :
        sel_ist ? {13'h0000, irq_st_q} :
        sel_imk ? {13'h0000, irq_mask_q} : 16'h0000;

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign irq = |(irq_st_q & irq_mask_q);
    assign diag_start = start_q;
    assign diag_abort = abort_q;
    assign diag_pair = pair_q;

    // loopback register next value: masked write, bit 0 fixed, bit 1
    // clears on read; a write in the same access wins over the clear
    always_comb begin
        lb_d = lb_q;
        if (rd_go && sel_lb) begin
            lb_d[LB_RC_BIT] = 1'b0;
        end
        if (wr_go && sel_lb) begin
            lb_d = (lb_q & ~(wmask & LB_WRITE_MASK))
                 | (wdat & wmask & LB_WRITE_MASK);
        end
    end

    // sticky status: write one clears, a new event in the same cycle wins
    always_comb begin
        irq_st_d = irq_st_q;
        if (wr_go && sel_ist && avs_byteenable[0]) begin
            irq_st_d = irq_st_q & ~wdat[IRQ_W-1:0];
        end
        irq_st_d = irq_st_d | ev;
    end

    // bus handshake and read data capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // loopback and interrupt registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lb_q <= LB_RESET;
            irq_st_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
        end else begin
            lb_q <= lb_d;
            irq_st_q <= irq_st_d;
            if (wr_go && sel_imk && avs_byteenable[0]) begin
                irq_mask_q <= wdat[IRQ_W-1:0];
            end
        end
    end

    // writable spare and pair fields of the cable register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            spare_q <= 1'b0;
            pair_q <= CD_PAIR_RESET;
            spare2_q <= 2'h0;
        end else if (cd_wr) begin
            spare_q <= wdat[CD_SPARE_BIT];
            pair_q <= wdat[CD_PAIR_LSB +: 2];
            spare2_q <= wdat[CD_SPARE2_LSB +: 2];
        end
    end

    // test sequencing: start, self clear on done, abort on zero write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            start_q <= cd_start;
            abort_q <= cd_abort;
            if (cd_start) begin
                busy_q <= 1'b1;
            end else if (cd_abort || cd_finish) begin
                busy_q <= 1'b0;
            end
        end
    end

    // result held until the next start; status bits ignore bus writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cable_q <= CD_STATUS_RESET;
        end else if (cd_start) begin
            cable_q <= CD_STATUS_RESET;
        end else if (cd_finish) begin
            cable_q <= diag_result;
        end
    end

    // link levels cross two flops before use; first stage read only here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gig_m_q <= 1'b0;
            gig_q <= 1'b0;
            fast_m_q <= 1'b0;
            fast_q <= 1'b0;
            gig_old_q <= 1'b0;
            fast_old_q <= 1'b0;
        end else begin
            gig_m_q <= link_gig_up;
            gig_q <= gig_m_q;
            fast_m_q <= link_fast_up;
            fast_q <= fast_m_q;
            gig_old_q <= gig_q;
            fast_old_q <= fast_q;
        end
    end

    // copper path: line receive goes back out on line transmit
    pdsr_loopback #(
        .WIDTH(LINE_W)
    ) u_copper_loop (
        .clk(clk),
        .rst_n(rst_n),
        .loop_en(lb_q[LB_ENABLE_BIT]),
        .ext_in_data(line_rx_data),
        .ext_in_valid(line_rx_valid),
        .fab_in_data(fab_tx_data),
        .fab_in_valid(fab_tx_valid),
        .ext_out_data(line_tx_data),
        .ext_out_valid(line_tx_valid),
        .fab_out_data(fab_rx_data),
        .fab_out_valid(fab_rx_valid)
    );

    // mii path: transmit pins come back on receive pins
    pdsr_loopback #(
        .WIDTH(MIP_W)
    ) u_mip_loop (
        .clk(clk),
        .rst_n(rst_n),
        .loop_en(lb_q[LB_ENABLE_BIT]),
        .ext_in_data(media_independent_port_txd),
        .ext_in_valid(media_independent_port_tx_en),
        .fab_in_data(mip_fab_data),
        .fab_in_valid(mip_fab_valid),
        .ext_out_data(media_independent_port_rxd),
        .ext_out_valid(media_independent_port_rx_dv),
        .fab_out_data(mip_to_fab_data),
        .fab_out_valid(mip_to_fab_valid)
    );

endmodule : pdsr_regs

/* File: testbench/pdsr_regs_chk.sv */
`timescale 1ns/1ps

// port-level checks on the register block
module pdsr_regs_chk #(
    parameter int LINE_W = 8,
    parameter int MIP_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pdsr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic diag_start,
    input wire logic diag_abort,
    input wire logic [1:0] diag_pair,
    input wire logic diag_done,
    input wire logic [1:0] diag_result,
    input wire logic [LINE_W-1:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic [LINE_W-1:0] line_tx_data,
    input wire logic line_tx_valid,
    input wire logic fab_tx_valid,
    input wire logic [LINE_W-1:0] fab_rx_data,
    input wire logic fab_rx_valid
);
    import pdsr_pkg::*;
    logic busy_q;
    logic busy_d;
    logic [1:0] res_q;
    logic [1:0] res_d;
    // access decode; shadow state follows start one cycle after the design, done and abort in the same cycle
    wire [9:0] idx = avs_address[11:2];
    wire acc_end = (avs_read | avs_write) & ~avs_waitrequest;
    wire rd_cd = acc_end & avs_read & (idx == IDX_CABLE_DIAG);
    wire wr_cd = acc_end & avs_write & (idx == IDX_CABLE_DIAG)
        & avs_byteenable[1];
    // a zero write ends a running test at once, done in that cycle is lost
    wire abort_wr = wr_cd & ~avs_writedata[CD_ENABLE_BIT];
    wire done_ok = diag_done & ~diag_abort & ~abort_wr
        & (busy_q | diag_start);
    assign busy_d = (diag_start | busy_q) & ~diag_done & ~diag_abort
        & ~abort_wr;
    assign res_d = done_ok ? diag_result : (diag_start ? 2'h0 : res_q);

    // shadow of the test state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            res_q <= 2'h0;
        end else begin
            busy_q <= busy_d;
            res_q <= res_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        wr_cd && avs_writedata[CD_ENABLE_BIT] && !busy_q && !diag_start;
    endsequence
    sequence s_idle_rd;
        rd_cd && !$past(busy_q) && !$past(diag_start);
    endsequence

    AST_BUS_WAIT:
        assert property (avs_waitrequest |-> (avs_read || avs_write)
            ##1 !avs_waitrequest) else $error("wait not one cycle");
    AST_EXT_CAP:
        assert property (acc_end && avs_read && idx == IDX_EXT_CAP
            |-> avs_readdata == 32'h0000_3000) else $error("capability");
    AST_FAB_RX:
        assert property (fab_rx_valid |-> $past(line_rx_valid)
            && fab_rx_data == $past(line_rx_data)) else $error("fab rx");
    AST_LINE_TX:
        assert property (line_tx_valid && !$past(fab_tx_valid)
            |-> line_tx_data == $past(line_rx_data)) else $error("line tx");
    AST_START:
        assert property (s_take |=> diag_start
            && diag_pair == $past(avs_writedata[13:12]))
            else $error("start");
    AST_NO_START:
        assert property (wr_cd && (!avs_writedata[15] || busy_q)
            |=> !diag_start) else $error("stray start");
    AST_ABORT:
        assert property (wr_cd && !avs_writedata[CD_ENABLE_BIT] && busy_q
            |=> diag_abort) else $error("no abort pulse");
    AST_BUSY_RD:
        assert property (rd_cd && $past(busy_q) |-> avs_readdata[15])
            else $error("busy bit");
    AST_IDLE_RD:
        assert property (s_idle_rd |-> !avs_readdata[15]
            && avs_readdata[9:8] == $past(res_q)) else $error("result");
endmodule : pdsr_regs_chk

bind pdsr_regs pdsr_regs_chk #(.LINE_W(LINE_W), .MIP_W(MIP_W)) chk_u (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .diag_start,
    .diag_abort, .diag_pair, .diag_done, .diag_result, .line_rx_data,
    .line_rx_valid, .line_tx_data, .line_tx_valid, .fab_tx_valid,
    .fab_rx_data, .fab_rx_valid
);

/* File: testbench/pdsr_regs_test.sv */
`timescale 1ns/1ps

// self-checking bench for the port register block
module pdsr_regs_test;
    import pdsr_pkg::*;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [15:0] d;
    } pdsr_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, diag_start, diag_abort;
    logic [1:0] diag_pair;
    logic diag_done = 1'b0;
    logic [1:0] diag_result = 2'h0;
    logic link_gig_up = 1'b1;
    logic link_fast_up = 1'b0;
    // constant traffic on every path but fabric transmit, quiet from the loopback pass on; the loop bit picks the source
    logic [7:0] line_rx_data = 8'ha5;
    logic line_rx_valid = 1'b1;
    logic [7:0] fab_tx_data = 8'h3c;
    logic fab_tx_valid = 1'b1;
    logic [3:0] media_independent_port_txd = 4'h9;
    logic media_independent_port_tx_en = 1'b1;
    logic [3:0] mip_fab_data = 4'h6;
    logic mip_fab_valid = 1'b1;
    logic [7:0] line_tx_data, fab_rx_data;
    logic line_tx_valid, fab_rx_valid;
    logic [3:0] media_independent_port_rxd, mip_to_fab_data;
    logic media_independent_port_rx_dv, mip_to_fab_valid;
    logic [31:0] rd;
    int n_fail = 0;
    int compares = 0;
    // reads carry the expected value in the data field
    pdsr_row_t rows [14] = '{
        '{1'b0, 12'h478, 16'h3000}, '{1'b1, 12'h478, 16'hffff},
        '{1'b0, 12'h478, 16'h3000}, '{1'b0, 12'h488, 16'h00f4},
        '{1'b0, 12'h490, 16'h0000}, '{1'b0, 12'h498, 16'h0002},
        '{1'b1, 12'h488, 16'hffff}, '{1'b0, 12'h488, 16'hfffe},
        '{1'b0, 12'h488, 16'hfffc}, '{1'b1, 12'h490, 16'h7f00},
        '{1'b0, 12'h490, 16'h7c00}, '{1'b1, 12'h490, 16'h0000},
        '{1'b1, 12'h400, 16'h1234}, '{1'b0, 12'h400, 16'h0000}};

    pdsr_regs #(.LINE_W(8), .MIP_W(4)) dut_u (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .diag_start,
        .diag_abort, .diag_pair, .diag_done, .diag_result, .link_gig_up,
        .link_fast_up, .line_rx_data, .line_rx_valid, .line_tx_data,
        .line_tx_valid, .fab_tx_data, .fab_tx_valid, .fab_rx_data,
        .fab_rx_valid, .media_independent_port_txd,
        .media_independent_port_tx_en, .media_independent_port_rxd,
        .media_independent_port_rx_dv, .mip_fab_data, .mip_fab_valid,
        .mip_to_fab_data, .mip_to_fab_valid
    );

    always #12.5 clk = ~clk;

    task automatic results();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [11:0] a,
            input logic [15:0] d, input logic [3:0] be);
        int i;
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        if (i >= 20) begin
            n_fail++;
            results();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : acc

    // pulse the measurement engine's completion with a result code
    task automatic finish_test(input logic [1:0] res);
        diag_result <= res;
        diag_done <= 1'b1;
        @(posedge clk);
        diag_done <= 1'b0;
    endtask : finish_test

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[k]) begin
            acc(rows[k].w, rows[k].a, rows[k].d, 4'h3);
            if (!rows[k].w) chk(rd, {16'h0000, rows[k].d});
        end
        // normal path, then loopback on copper and mii
        for (int m = 0; m < 2; m++) begin
            // fabric quiet in loopback so looped line data is told apart
            fab_tx_valid <= (m == 0);
            acc(1'b1, 12'h488, m ? 16'h0100 : 16'h0000, 4'h3);
            @(negedge clk);
            chk({16'h0000, line_tx_valid, fab_rx_valid, line_tx_data,
                media_independent_port_rx_dv, mip_to_fab_valid,
                media_independent_port_rxd},
                m ? 32'h0000_a969 : 32'h0000_cf36);
            chk({20'h0_0000, fab_rx_data, mip_to_fab_data}, 32'h0000_0a59);
            @(posedge clk);
        end
        // every pair, each with the result code of the same number
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 12'h490, 16'h8000 | (16'(k) << 12), 4'h3);
            chk({30'h0, diag_pair}, 32'(k));
            acc(1'b0, 12'h490, 16'h0000, 4'h3);
            chk(rd, 32'h0000_8000 | (32'(k) << 12));
            finish_test(2'(k));
            acc(1'b0, 12'h490, 16'h0000, 4'h3);
            chk(rd, (32'(k) << 12) | (32'(k) << 8));
        end
        // done events raise irq only once unmasked
        chk({31'h0, irq}, 32'h0000_0000);
        acc(1'b1, 12'h4c4, 16'h0001, 4'h3);
        chk({31'h0, irq}, 32'h0000_0001);
        acc(1'b1, 12'h4c0, 16'h0007, 4'h3);
        chk({31'h0, irq}, 32'h0000_0000);
        // upper lane off must not abort; zero write aborts
        acc(1'b1, 12'h490, 16'h9000, 4'h3);
        acc(1'b1, 12'h490, 16'h0000, 4'h1);
        acc(1'b0, 12'h490, 16'h0000, 4'h3);
        chk(rd, 32'h0000_9000);
        acc(1'b1, 12'h490, 16'h0000, 4'h3);
        finish_test(2'h2);
        acc(1'b0, 12'h490, 16'h0000, 4'h3);
        chk(rd, 32'h0000_0000);
        link_fast_up <= 1'b1;
        repeat (5) @(posedge clk);
        acc(1'b0, 12'h498, 16'h0000, 4'h3);
        chk(rd, 32'h0000_0003);
        // only the 100 Mb/s change has happened since the last clear
        acc(1'b0, 12'h4c0, 16'h0000, 4'h3);
        chk(rd, 32'h0000_0004);
        // mid-run reset restores the loopback default
        acc(1'b1, 12'h488, 16'h0100, 4'h3);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        acc(1'b0, 12'h488, 16'h0000, 4'h3);
        chk(rd, 32'h0000_00f4);
        results();
    end
endmodule : pdsr_regs_test
